// ==== src/ldbe_cfg.svh ====
// constants of the lane dc balance encoder: lane geometry, disparity limits, slot timing
// assumes it is included once per compilation unit, before ldbe_pkg
`ifndef LDBE_CFG_SVH
`define LDBE_CFG_SVH

// ----------------------------------------------------------------------------
// lane geometry
// ----------------------------------------------------------------------------
`define LDBE_DATA_BITS      48
`define LDBE_LANES          8
`define LDBE_WORD_BITS      6
`define LDBE_SLOT_BITS      7
`define LDBE_FLAG_POS       6
`define LDBE_CNT_W          3

// ----------------------------------------------------------------------------
// running disparity
// ----------------------------------------------------------------------------
`define LDBE_RD_MAX         6'sh07
`define LDBE_RD_MIN         -6'sh06
`define LDBE_RD_RESET       4'sh0

// ----------------------------------------------------------------------------
// link slot timing, in link clock cycles
// ----------------------------------------------------------------------------
`define LDBE_SLOT_LAST      3'h6
`define LDBE_CLK_HIGH_BITS  3'h4

`endif

// ==== src/ldbe_lane_coder.sv ====
// combinational dc balance decision and disparity update for one lane word
// assumes rd_i lies within the saturation range
`timescale 1ns/1ps
`default_nettype none
`include "ldbe_cfg.svh"

module ldbe_lane_coder
    import ldbe_pkg::*;
(
    input  wire logic [`LDBE_WORD_BITS-1:0] word_i,
    input  wire ldbe_rd_t                   rd_i,
    output logic                            flag_o,
    output logic      [`LDBE_WORD_BITS-1:0] word_o,
    output ldbe_rd_t                        rd_o
);
    logic [2:0] ones;
    ldbe_disp_t disp;
    ldbe_sum_t  sum;

    always_comb begin
        ones = 3'h0;
        for (int i = 0; i < `LDBE_WORD_BITS; i++) begin
            ones = ones + {2'h0, word_i[i]};
        end
        disp = $signed({1'b0, ones, 1'b0}) - 5'sh06;
        if (rd_i == 4'sh0) begin
            flag_o = 1'b1;
        end else if (rd_i > 4'sh0) begin
            flag_o = (disp > 5'sh00);
        end else begin
            flag_o = (disp <= 5'sh00);
        end
        word_o = flag_o ? ~word_i : word_i;
        if (flag_o) begin
            sum = ldbe_sum_t'(rd_i) + 6'sh01 - ldbe_sum_t'(disp);
        end else begin
            sum = ldbe_sum_t'(rd_i) + ldbe_sum_t'(disp) - 6'sh01;
        end
        if (sum > `LDBE_RD_MAX) begin
            rd_o = ldbe_rd_t'(`LDBE_RD_MAX);
        end else if (sum < `LDBE_RD_MIN) begin
            rd_o = ldbe_rd_t'(`LDBE_RD_MIN);
        end else begin
            rd_o = ldbe_rd_t'(sum);
        end
    end

endmodule : ldbe_lane_coder

`default_nettype wire

// ==== src/ldbe_pkg.sv ====
// types shared by the lane dc balance encoder modules
// assumes ldbe_cfg.svh is on the include path
`include "ldbe_cfg.svh"

package ldbe_pkg;

    typedef logic signed [3:0] ldbe_rd_t;
    typedef logic signed [4:0] ldbe_disp_t;
    typedef logic signed [5:0] ldbe_sum_t;

    typedef logic [`LDBE_SLOT_BITS-1:0] ldbe_slot_t;

    typedef struct packed {
        logic                                 balance_mode_select;
        logic [`LDBE_LANES-1:0][`LDBE_SLOT_BITS-1:0] slot;
    } ldbe_frame_t;

    typedef enum logic [0:0] {
        LDBE_ST_IDLE,
        LDBE_ST_WAIT
    } ldbe_state_t;

endpackage : ldbe_pkg

// ==== src/ldbe_sync.sv ====
// two flip-flop synchroniser for levels and toggles
// assumes d_i is stable long enough to be seen by clk_i
`timescale 1ns/1ps
`default_nettype none

module ldbe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] safe_reg;
    logic [WIDTH-1:0] safe_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = d_i;
        safe_next = meta_reg;
    end

    always_ff @(posedge clk_i) begin
        meta_reg <= meta_next;
        safe_reg <= safe_next;
    end

    assign q_o = safe_reg;

endmodule : ldbe_sync

`default_nettype wire

// ==== src/ldbe_top.sv ====
// lane dc balance encoder and serializer: 48 parallel bits in, eight serial lanes plus a link clock out
// assumes clk_i is the parallel side clock and link_clk_i a free running bit clock, unrelated in phase
`timescale 1ns/1ps
`default_nettype none
`include "ldbe_cfg.svh"

module ldbe_top
    import ldbe_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       link_clk_i,
    input  wire logic [`LDBE_DATA_BITS-1:0] data_i,
    input  wire logic                       data_valid_i,
    output logic                            data_ready_o,
    input  wire logic                       balance_mode_select_i,
    output logic      [`LDBE_LANES-1:0]     lane_o,
    output logic                            tx_clk_o
);

    // ------------------------------------------------------------------------
    // parallel side declarations
    // ------------------------------------------------------------------------
    ldbe_state_t                          state_reg;
    ldbe_state_t                          state_next;
    logic                                 ready_reg;
    logic                                 ready_next;
    logic                                 req_reg;
    logic                                 req_next;
    ldbe_frame_t                          hold_reg;
    ldbe_frame_t                          hold_next;
    ldbe_rd_t [`LDBE_LANES-1:0]           rd_reg;
    ldbe_rd_t [`LDBE_LANES-1:0]           rd_next;
    ldbe_rd_t [`LDBE_LANES-1:0]           rd_coded;
    logic     [`LDBE_LANES-1:0]           flag_coded;
    logic     [`LDBE_LANES-1:0][`LDBE_WORD_BITS-1:0] word_coded;
    logic     [`LDBE_LANES*`LDBE_SLOT_BITS-1:0]      legacy_bits;
    logic                                 bal_core;
    logic                                 ack_core;
    logic                                 accept;

    // ------------------------------------------------------------------------
    // link side declarations
    // ------------------------------------------------------------------------
    logic                                 link_rstn;
    logic                                 req_link;
    logic                                 seen_reg;
    logic                                 seen_next;
    logic [`LDBE_CNT_W-1:0]               bit_cnt_reg;
    logic [`LDBE_CNT_W-1:0]               bit_cnt_next;
    logic [`LDBE_LANES-1:0][`LDBE_SLOT_BITS-1:0]     shift_reg;
    logic [`LDBE_LANES-1:0][`LDBE_SLOT_BITS-1:0]     shift_next;
    logic                                 clk_out_reg;
    logic                                 clk_out_next;

    // ------------------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------------------
    // the mode pin is asynchronous to both clocks; it is only sampled into a
    // frame at word acceptance, so a change takes effect on a word boundary
    ldbe_sync #(
        .WIDTH (1)
    ) u_mode_sync (
        .clk_i (clk_i),
        .d_i   (balance_mode_select_i),
        .q_o   (bal_core)
    );

    // link side reset follows the parallel reset two link edges late
    ldbe_sync #(
        .WIDTH (1)
    ) u_link_rst_sync (
        .clk_i (link_clk_i),
        .d_i   (rstn_i),
        .q_o   (link_rstn)
    );

    ldbe_sync #(
        .WIDTH (1)
    ) u_req_sync (
        .clk_i (link_clk_i),
        .d_i   (req_reg),
        .q_o   (req_link)
    );

    ldbe_sync #(
        .WIDTH (1)
    ) u_ack_sync (
        .clk_i (clk_i),
        .d_i   (seen_reg),
        .q_o   (ack_core)
    );

    // ------------------------------------------------------------------------
    // per lane balance coders
    // ------------------------------------------------------------------------
    // six input bits per lane, lane k takes data_i[6k+5:6k]
    for (genvar k = 0; k < `LDBE_LANES; k++) begin : g_lane
        ldbe_lane_coder u_coder (
            .word_i (data_i[k*`LDBE_WORD_BITS +: `LDBE_WORD_BITS]),
            .rd_i   (rd_reg[k]),
            .flag_o (flag_coded[k]),
            .word_o (word_coded[k]),
            .rd_o   (rd_coded[k])
        );
        assign lane_o[k] = shift_reg[k][0];
    end

    // legacy order: seven bits per lane from the bottom up, top slots padded
    assign legacy_bits = {{(`LDBE_LANES*`LDBE_SLOT_BITS-`LDBE_DATA_BITS){1'b0}}, data_i};

    // ------------------------------------------------------------------------
    // parallel side word acceptance
    // ------------------------------------------------------------------------
    // one word is in flight at a time; the hold register stays untouched until
    // the link side has loaded it and the acknowledge toggle has come back
    assign accept = data_valid_i & ready_reg;

    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        hold_next  = hold_reg;
        rd_next    = rd_reg;
        case (state_reg)
            LDBE_ST_IDLE: begin
                if (accept) begin
                    hold_next.balance_mode_select = bal_core;
                    for (int k = 0; k < `LDBE_LANES; k++) begin
                        if (bal_core) begin
                            hold_next.slot[k] = {flag_coded[k], word_coded[k]};
                            rd_next[k]        = rd_coded[k];
                        end else begin
                            hold_next.slot[k] = legacy_bits[k*`LDBE_SLOT_BITS +: `LDBE_SLOT_BITS];
                        end
                    end
                    req_next   = ~req_reg;
                    state_next = LDBE_ST_WAIT;
                end
            end
            LDBE_ST_WAIT: begin
                if (ack_core == req_reg) begin
                    state_next = LDBE_ST_IDLE;
                end
            end
            default: begin
                state_next = LDBE_ST_IDLE;
            end
        endcase
        ready_next = (state_next == LDBE_ST_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= LDBE_ST_IDLE;
            ready_reg <= 1'b0;
            req_reg   <= 1'b0;
            hold_reg  <= '0;
            rd_reg    <= {`LDBE_LANES{`LDBE_RD_RESET}};
        end else begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            req_reg   <= req_next;
            hold_reg  <= hold_next;
            rd_reg    <= rd_next;
        end
    end

    assign data_ready_o = ready_reg;

    // ------------------------------------------------------------------------
    // link side serializer
    // ------------------------------------------------------------------------
    // seven bit slots, least significant bit first, flag bit last; the slot
    // counter runs free so the link clock pattern never stops between words,
    // idle slots carry zeros
    always_comb begin
        seen_next    = seen_reg;
        bit_cnt_next = bit_cnt_reg + 3'h1;
        for (int k = 0; k < `LDBE_LANES; k++) begin
            shift_next[k] = {1'b0, shift_reg[k][`LDBE_SLOT_BITS-1:1]};
        end
        if (bit_cnt_reg == `LDBE_SLOT_LAST) begin
            bit_cnt_next = 3'h0;
            if (req_link != seen_reg) begin
                shift_next = hold_reg.slot;
                seen_next  = req_link;
            end else begin
                shift_next = '0;
            end
        end
        clk_out_next = (bit_cnt_next < `LDBE_CLK_HIGH_BITS);
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rstn) begin
            seen_reg    <= 1'b0;
            bit_cnt_reg <= 3'h0;
            shift_reg   <= '0;
            clk_out_reg <= 1'b1;
        end else begin
            seen_reg    <= seen_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
            clk_out_reg <= clk_out_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // lane bits leave from bit 0 of each shift register inside g_lane
    assign tx_clk_o = clk_out_reg;

endmodule : ldbe_top

`default_nettype wire

// ==== tb/ldbe_rx_model.sv ====
// far end receiver: frames slots on the link clock and undoes inversion
// assumes an all zero slot is idle, so a sent word never is all zero
`timescale 1ns/1ps
`default_nettype none

module ldbe_rx_model
    import ldbe_pkg::*;
(
    input  wire logic        link_clk_i,
    input  wire logic [7:0]  lane_i,
    input  wire logic        tx_clk_i,
    output logic      [55:0] raw_o,
    output logic      [47:0] word_o,
    output int               cnt_o
);
    logic [55:0] sh;
    logic        prev;
    int          idx;
    initial begin
        cnt_o = 0;
        idx = 7;
        prev = 1'b1;
    end
    // slot starts where the forwarded clock rises
    always @(posedge link_clk_i) begin
        idx = (tx_clk_i && !prev) ? 0 : idx + 1;
        prev = tx_clk_i;
        if (idx < 7) begin
            for (int k = 0; k < 8; k++) sh[7*k+idx] = lane_i[k];
            if (idx == 6 && sh != 56'h0) begin
                raw_o = sh;
                for (int k = 0; k < 8; k++) word_o[6*k+:6] = sh[7*k+:6] ^ {6{sh[7*k+6]}};
                cnt_o++;
            end
        end
    end
endmodule : ldbe_rx_model

`default_nettype wire

// ==== tb/ldbe_top_properties.sv ====
// port assertions for the lane dc balance encoder
// assumes both clocks run while rstn_i is low
`timescale 1ns/1ps
`default_nettype none
`include "ldbe_cfg.svh"

module ldbe_props
    import ldbe_pkg::*;
(
    input wire logic                       clk_i,
    input wire logic                       rstn_i,
    input wire logic                       link_clk_i,
    input wire logic [`LDBE_DATA_BITS-1:0] data_i,
    input wire logic                       data_valid_i,
    input wire logic                       data_ready_o,
    input wire logic                       balance_mode_select_i,
    input wire logic [`LDBE_LANES-1:0]     lane_o,
    input wire logic                       tx_clk_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // link cycles since the mode pin went low, saturating
    logic [5:0] low_cnt_reg;
    logic [5:0] low_cnt_next;
    always_comb begin
        low_cnt_next = balance_mode_select_i ? 6'h00 : low_cnt_reg + {5'h00, low_cnt_reg != 6'h3f};
    end
    always_ff @(posedge link_clk_i) begin
        low_cnt_reg <= low_cnt_next;
    end
    sequence clk_hi_s;
        tx_clk_o [*4];
    endsequence
    sequence clk_lo_s;
        !tx_clk_o [*3];
    endsequence
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    ready_hold_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_valid_i && data_ready_o |=> !data_ready_o [*2]) else $error("ready back too soon");
    ready_back_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_valid_i && data_ready_o |-> ##[1:20] data_ready_o) else $error("ready never returned");
    ready_stay_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_ready_o && !data_valid_i |=> data_ready_o) else $error("ready dropped unasked");
    ready_rst_a : assert property (@(posedge clk_i)
        !rstn_i |=> !data_ready_o) else $error("ready high in reset");
    slot_high_a : assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        $rose(tx_clk_o) |-> clk_hi_s ##1 clk_lo_s ##1 tx_clk_o) else $error("slot clock high phase");
    slot_low_a : assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        $fell(tx_clk_o) |-> clk_lo_s ##1 clk_hi_s) else $error("slot clock low phase");
    lane_rst_a : assert property (@(posedge link_clk_i)
        !rstn_i [*5] |-> lane_o == 8'h00 && tx_clk_o) else $error("link not idle in reset");
    legacy_lane_a : assert property (@(posedge link_clk_i) disable iff (!rstn_i)
        low_cnt_reg == 6'h3f |-> !lane_o[7]) else $error("lane 7 busy unbalanced");
endmodule : ldbe_props

bind ldbe_top ldbe_props u_props (.clk_i, .rstn_i, .link_clk_i, .data_i, .data_valid_i,
    .data_ready_o, .balance_mode_select_i, .lane_o, .tx_clk_o);

`default_nettype wire

// ==== tb/tb_ldbe_top.sv ====
// self-checking bench for the lane dc balance encoder
// assumes the receiver model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none

module tb_ldbe_top
    import ldbe_pkg::*;
;
    typedef struct packed {
        logic        mode;
        logic [47:0] data;
    } ldbe_row_t;
    logic        clk, rstn, lclk, valid, ready, mode, txc;
    logic [47:0] data, word;
    logic [7:0]  lane;
    logic [55:0] raw;
    int          cnt, c0, bad_count, checks;
    int          rd [8];
    ldbe_row_t   rows [10] = '{'{1'b1, 48'h0}, '{1'b1, 48'hfff000fff000}, '{1'b1, 48'h555555aaaaaa},
        '{1'b1, 48'h0410c30c4103}, '{1'b1, 48'hfc0fc0fc0fc0}, '{1'b0, 48'h123456789abc},
        '{1'b0, 48'hffffffffffff}, '{1'b1, 48'h000fff000fff}, '{1'b1, 48'h249249249249},
        '{1'b1, 48'hffffffffffff}};

    always #25 clk = ~clk;
    initial begin
        lclk = 1'b0;
        #1.4;
        forever #3 lclk = ~lclk;
    end

    ldbe_top u_dut (.clk_i(clk), .rstn_i(rstn), .link_clk_i(lclk), .data_i(data), .data_valid_i(valid),
        .data_ready_o(ready), .balance_mode_select_i(mode), .lane_o(lane), .tx_clk_o(txc));
    ldbe_rx_model u_rx (.link_clk_i(lclk), .lane_i(lane), .tx_clk_i(txc), .raw_o(raw), .word_o(word),
        .cnt_o(cnt));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task check(input logic [55:0] seen, input logic [55:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // expected slots; running disparity model advances per balanced mode word
    function automatic logic [55:0] slots(input logic m, input logic [47:0] d);
        logic [55:0] e;
        int          disp;
        logic        inv;
        e = {8'h00, d};
        if (m) for (int k = 0; k < 8; k++) begin
            disp = 2 * $countones(d[6*k+:6]) - 6;
            inv = rd[k] == 0 || ((rd[k] > 0) == (disp > 0));
            rd[k] += inv ? 1 - disp : disp - 1;
            rd[k] = rd[k] > 7 ? 7 : (rd[k] < -6 ? -6 : rd[k]);
            e[7*k+:7] = {inv, d[6*k+:6] ^ {6{inv}}};
        end
        return e;
    endfunction : slots

    task offer(input logic m, input logic [47:0] d);
        int n;
        mode = m;
        repeat (4) @(posedge clk);
        #1;
        for (n = 0; ready !== 1'b1; n++) begin
            if (n > 100) begin bad_count++; stop_test(); end
            @(posedge clk);
            #1;
        end
        c0 = cnt;
        data = d;
        valid = 1'b1;
        @(posedge clk);
        #1;
        valid = 1'b0;
    endtask : offer

    task collect(input logic m, input logic [47:0] d);
        int          n;
        logic [55:0] e;
        e = slots(m, d);
        for (n = 0; cnt == c0; n++) begin
            if (n > 100) begin bad_count++; stop_test(); end
            @(posedge clk);
            #1;
        end
        check(raw, e);
        if (m) check({8'h00, word}, {8'h00, d});
    endtask : collect

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        valid = 1'b0;
        data = 48'h0;
        mode = 1'b1;
        bad_count = 0;
        checks = 0;
        rd = '{default: 0};
        repeat (7) @(posedge clk);
        #1;
        check({55'h0, ready}, 56'h0);
        @(posedge clk);
        #1;
        rstn = 1'b1;
        foreach (rows[i]) begin
            offer(rows[i].mode, rows[i].data);
            collect(rows[i].mode, rows[i].data);
            $display("row %0d done", i);
        end
        // offer while busy must be ignored
        offer(1'b1, 48'h00f0f00f0f0f);
        @(posedge clk);
        #1;
        data = 48'hfff0ff0fff0f;
        valid = 1'b1;
        @(posedge clk);
        #1;
        valid = 1'b0;
        collect(1'b1, 48'h00f0f00f0f0f);
        repeat (30) @(posedge clk);
        #1;
        check(56'(cnt), 56'(c0 + 1));
        $display("busy offer done");
        // mid-run reset restarts disparity at zero, so every lane inverts
        rstn = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check({55'h0, ready}, 56'h0);
        rstn = 1'b1;
        rd = '{default: 0};
        offer(1'b1, 48'h0);
        collect(1'b1, 48'h0);
        $display("reset restart done");
        stop_test();
    end
endmodule : tb_ldbe_top

`default_nettype wire
